//--- include/usart_rx_regs.svh
`ifndef USART_RX_REGS_SVH
`define USART_RX_REGS_SVH

// ----------------------------------------------------------------
// register indices and byte addresses
// ----------------------------------------------------------------
`define RECEIVE_STATUS_CONTROL_INDEX      12'h013
`define TXSTA_INDEX      12'h015
`define BANK4_BASE       12'h400
`define IRQ_STAT_ADDR    12'h800
`define IRQ_MASK_ADDR    12'h804

// ----------------------------------------------------------------
// receive status and control fields
// ----------------------------------------------------------------
`define RC_PORT_ON       7
`define RC_NINE_SEL      6
`define RC_SINGLE_EN     5
`define RC_CONT_EN       4
`define RC_FRAME_ERR     2
`define RC_OVERRUN       1
`define RC_NINTH_BIT     0
`define RC_WR_MASK       8'h00_F0
`define RC_RESET         8'h00_00

// ----------------------------------------------------------------
// transmit control fields
// ----------------------------------------------------------------
`define TX_CLK_SRC       7
`define TX_NINE_SEL      6
`define TX_ENABLE        5
`define TX_SYNC_MODE     4
`define TX_SHIFT_EMPTY   1
`define TX_NINTH_BIT     0
`define TX_WR_MASK       8'h00_F1
`define TX_RESET         8'h00_00

// ----------------------------------------------------------------
// interrupt status bit positions, per channel at 4*channel
// ----------------------------------------------------------------
`define IRQ_BYTE_DONE    0
`define IRQ_FRAME_ERR    1
`define IRQ_OVERRUN      2
`define IRQ_CH_STRIDE    4
`define IRQ_IMPL_MASK    8'h00_77

`endif

//--- include/usart_rx_pkg.sv
package usart_rx_pkg;

  // event from the receive datapath, one cycle pulse in byte_done
  typedef struct packed {
    logic byte_done;
    logic ninth_bit;
    logic frame_err;
    logic overrun;
  } rx_event_t;

  // pin ownership, direction and mode seen by the datapath
  typedef struct packed {
    logic port_own;
    logic clk_pin_oe;
    logic data_pin_oe;
    logic rx_active;
    logic tx_active;
    logic sync_mode;
    logic nine_bit;
  } pin_ctl_t;

  typedef enum logic [2:0] {
    SEL_NONE  = 3'b000,
    SEL_RC0   = 3'b001,
    SEL_TX0   = 3'b010,
    SEL_RC1   = 3'b011,
    SEL_TX1   = 3'b100,
    SEL_ISTAT = 3'b101,
    SEL_IMASK = 3'b110
  } reg_sel_t;

endpackage

//--- logic/usart_rx_chan.sv
`timescale 1ns/100ps
`include "usart_rx_regs.svh"

module usart_rx_chan
  import usart_rx_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       receive_status_control_we,
  input  wire logic       txsta_we,
  input  wire logic [7:0] wdata,
  input  wire rx_event_t  rx_ev,
  input  wire logic       shift_empty,
  output logic [7:0]      receive_status_control_q,
  output logic [7:0]      txsta_q,
  output pin_ctl_t        pins_r
);

  logic [7:0] receive_status_control_r;
  logic [7:0] receive_status_control_nxt;
  logic [7:0] txsta_r;
  logic [7:0] txsta_nxt;
  pin_ctl_t   pins_nxt;
  logic       sync_rx;
  logic       rx_on;

  // ----------------------------------------------------------------
  // register next state
  // ----------------------------------------------------------------
  always_comb begin
    receive_status_control_nxt = receive_status_control_r;
    txsta_nxt = txsta_r;
    if (txsta_we) begin
      txsta_nxt = (wdata & `TX_WR_MASK) | (txsta_r & ~`TX_WR_MASK);
    end
    if (receive_status_control_we) begin
      receive_status_control_nxt = (wdata & `RC_WR_MASK) | (receive_status_control_r & ~`RC_WR_MASK);
      if (!wdata[`RC_CONT_EN]) begin
        receive_status_control_nxt[`RC_OVERRUN] = 1'b0;
      end
    end
    if (rx_ev.byte_done) begin
      receive_status_control_nxt[`RC_FRAME_ERR] = rx_ev.frame_err;
      if (receive_status_control_r[`RC_NINE_SEL]) begin
        receive_status_control_nxt[`RC_NINTH_BIT] = rx_ev.ninth_bit;
      end
      // single receive ends after one byte in synchronous master mode
      if (txsta_r[`TX_SYNC_MODE] && txsta_r[`TX_CLK_SRC]) begin
        receive_status_control_nxt[`RC_SINGLE_EN] = 1'b0;
      end
    end
    if (rx_ev.overrun) begin
      receive_status_control_nxt[`RC_OVERRUN] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // pin ownership and direction
  // ----------------------------------------------------------------
  always_comb begin
    // single receive is ignored as a slave; continuous overrides it
    sync_rx = receive_status_control_r[`RC_CONT_EN] |
              (receive_status_control_r[`RC_SINGLE_EN] & txsta_r[`TX_CLK_SRC]);
    rx_on   = txsta_r[`TX_SYNC_MODE] ? sync_rx
                                     : receive_status_control_r[`RC_CONT_EN];
    pins_nxt.port_own    = receive_status_control_r[`RC_PORT_ON];
    pins_nxt.sync_mode   = txsta_r[`TX_SYNC_MODE];
    pins_nxt.nine_bit    = receive_status_control_r[`RC_NINE_SEL];
    pins_nxt.rx_active   = receive_status_control_r[`RC_PORT_ON] & rx_on;
    pins_nxt.tx_active   = receive_status_control_r[`RC_PORT_ON] & txsta_r[`TX_ENABLE] &
                           ~(txsta_r[`TX_SYNC_MODE] & sync_rx);
    pins_nxt.clk_pin_oe  = receive_status_control_r[`RC_PORT_ON] &
                           (~txsta_r[`TX_SYNC_MODE] |
                            txsta_r[`TX_CLK_SRC]);
    pins_nxt.data_pin_oe = pins_nxt.tx_active &
                           txsta_r[`TX_SYNC_MODE];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receive_status_control_r <= `RC_RESET;
      txsta_r <= `TX_RESET;
      pins_r  <= '0;
    end else begin
      receive_status_control_r <= receive_status_control_nxt;
      txsta_r <= txsta_nxt;
      pins_r  <= pins_nxt;
    end
  end

  always_comb begin
    receive_status_control_q = receive_status_control_r;
    txsta_q = txsta_r;
    txsta_q[`TX_SHIFT_EMPTY] = shift_empty;
    txsta_q[3:2] = 2'b00;
  end

endmodule

//--- logic/usart_receive_control.sv
// Chosen here: register access over APB.
`timescale 1ns/100ps
`include "usart_rx_regs.svh"


module usart_receive_control
  import usart_rx_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire rx_event_t [1:0]  rx_ev,
  input  wire logic [1:0]       shift_empty,
  output pin_ctl_t [1:0]        pins,
  output logic                  irq
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // byte address of a word-sized register from its index
  function automatic logic [11:0] index_addr(input logic [11:0] idx);
    return {idx[9:0], 2'b00};
  endfunction

  function automatic reg_sel_t decode(input logic [11:0] a);
    reg_sel_t s;
    s = SEL_NONE;
    if (a == index_addr(`RECEIVE_STATUS_CONTROL_INDEX)) begin
      s = SEL_RC0;
    end else if (a == index_addr(`TXSTA_INDEX)) begin
      s = SEL_TX0;
    end else if (a == (`BANK4_BASE | index_addr(`RECEIVE_STATUS_CONTROL_INDEX))) begin
      s = SEL_RC1;
    end else if (a == (`BANK4_BASE | index_addr(`TXSTA_INDEX))) begin
      s = SEL_TX1;
    end else if (a == `IRQ_STAT_ADDR) begin
      s = SEL_ISTAT;
    end else if (a == `IRQ_MASK_ADDR) begin
      s = SEL_IMASK;
    end
    return s;
  endfunction

  reg_sel_t    sel;
  logic        wr_go;
  logic [7:0]  wbyte;
  logic [1:0]  rc_we;
  logic [1:0]  tx_we;
  logic [7:0]  rc_q [2];
  logic [7:0]  tx_q [2];

  always_comb begin
    sel   = decode(paddr);
    wr_go = psel & penable & pready & pwrite & ~pslverr;
    wbyte = pwdata[7:0];
    rc_we = {wr_go & (sel == SEL_RC1), wr_go & (sel == SEL_RC0)};
    tx_we = {wr_go & (sel == SEL_TX1), wr_go & (sel == SEL_TX0)};
  end

  // ----------------------------------------------------------------
  // the two channels
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_ch
    usart_rx_chan u_chan (
      .pclk        (pclk),
      .presetn     (presetn),
      .receive_status_control_we    (rc_we[i]),
      .txsta_we    (tx_we[i]),
      .wdata       (wbyte),
      .rx_ev       (rx_ev[i]),
      .shift_empty (shift_empty[i]),
      .receive_status_control_q     (rc_q[i]),
      .txsta_q     (tx_q[i]),
      .pins_r      (pins[i])
    );
  end

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  logic [7:0] istat_r;
  logic [7:0] istat_nxt;
  logic [7:0] imask_r;
  logic [7:0] imask_nxt;
  logic       irq_nxt;
  logic [7:0] ev_set;

  always_comb begin
    ev_set = '0;
    for (int i = 0; i < 2; i++) begin
      ev_set[i*`IRQ_CH_STRIDE + `IRQ_BYTE_DONE] = rx_ev[i].byte_done;
      ev_set[i*`IRQ_CH_STRIDE + `IRQ_FRAME_ERR] = rx_ev[i].byte_done &
                                                  rx_ev[i].frame_err;
      ev_set[i*`IRQ_CH_STRIDE + `IRQ_OVERRUN]   = rx_ev[i].overrun;
    end
    istat_nxt = istat_r;
    imask_nxt = imask_r;
    if (wr_go && sel == SEL_ISTAT) begin
      istat_nxt = istat_r & ~wbyte;
    end
    if (wr_go && sel == SEL_IMASK) begin
      imask_nxt = wbyte & `IRQ_IMPL_MASK;
    end
    // a new event wins over a clear in the same cycle
    istat_nxt = istat_nxt | ev_set;
    irq_nxt   = |(istat_nxt & imask_nxt);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_r <= 8'h00_00;
      imask_r <= 8'h00_00;
      irq     <= 1'b0;
    end else begin
      istat_r <= istat_nxt;
      imask_r <= imask_nxt;
      irq     <= irq_nxt;
    end
  end

  // ----------------------------------------------------------------
  // apb answer: no wait state, data captured in the setup cycle
  // ----------------------------------------------------------------
  logic [31:0] prdata_nxt;
  logic        pready_nxt;
  logic        pslverr_nxt;

  always_comb begin
    prdata_nxt  = prdata;
    pready_nxt  = psel & ~penable;
    pslverr_nxt = 1'b0;
    if (psel && !penable) begin
      prdata_nxt  = 32'h0000_0000;
      pslverr_nxt = (sel == SEL_NONE);
      if (!pwrite) begin
        case (sel)
          SEL_RC0:   prdata_nxt[7:0] = rc_q[0];
          SEL_TX0:   prdata_nxt[7:0] = tx_q[0];
          SEL_RC1:   prdata_nxt[7:0] = rc_q[1];
          SEL_TX1:   prdata_nxt[7:0] = tx_q[1];
          SEL_ISTAT: prdata_nxt[7:0] = istat_r;
          SEL_IMASK: prdata_nxt[7:0] = imask_r;
          default:   prdata_nxt[7:0] = 8'h00_00;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= prdata_nxt;
      pready  <= pready_nxt;
      pslverr <= pslverr_nxt;
    end
  end

endmodule

//--- tb/rx_datapath_model.sv
`timescale 1ns/100ps

module rx_datapath_model
  import usart_rx_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       fire,
  input  wire logic       chan,
  input  wire rx_event_t  ev_in,
  output rx_event_t [1:0] rx_ev,
  output logic [1:0]      shift_empty
);
  // ----------------------------------------------------------------
  // one-cycle event beats, qualified fields scrambled when idle
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_ev       <= '0;
      shift_empty <= 2'b01;
    end else begin
      for (int i = 0; i < 2; i++) begin
        rx_ev[i] <= {1'b0, ~rx_ev[i].ninth_bit, ~rx_ev[i].frame_err, 1'b0};
      end
      if (fire) begin
        rx_ev[chan] <= ev_in;
      end
    end
  end
endmodule

//--- tb/usart_receive_control_monitor.sv
`timescale 1ns/100ps

module usart_receive_control_monitor
  import usart_rx_pkg::*;
(
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [11:0]     paddr,
  input wire logic [31:0]     pwdata,
  input wire logic [31:0]     prdata,
  input wire logic            pready,
  input wire logic            pslverr,
  input wire pin_ctl_t [1:0]  pins,
  input wire logic            irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic setup;
  logic wr_done;
  assign setup   = psel && !penable;
  assign wr_done = psel && penable && pready && pwrite;

  AST_READY_ONE: assert property (setup |=> pready ##1 !pready)
    else $error("ready not a single cycle");
  AST_UNMAPPED: assert property (
    setup && !(paddr inside {12'h04C, 12'h054, 12'h44C, 12'h454,
    12'h800, 12'h804}) |=> pslverr)
    else $error("unmapped address not refused");
  AST_MAPPED: assert property (
    setup && paddr == 12'h44C |=> pready && !pslverr)
    else $error("second channel register refused");
  AST_HIGH_ZERO: assert property (
    pready |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  AST_PORT_OWN: assert property (
    wr_done && paddr == 12'h04C |->
    ##2 pins[0].port_own == $past(pwdata[7], 2))
    else $error("port ownership not following write");
  AST_SYNC_SEL: assert property (
    wr_done && paddr == 12'h054 |->
    ##2 pins[0].sync_mode == $past(pwdata[4], 2))
    else $error("link mode not following write");
  AST_NINE_SEL: assert property (
    wr_done && paddr == 12'h44C |->
    ##2 pins[1].nine_bit == $past(pwdata[6], 2))
    else $error("nine bit select not following write");
  AST_RX_OVER_TX: assert property (
    pins[0].sync_mode && pins[0].rx_active |-> !pins[0].tx_active)
    else $error("transmit active during sync receive");
  AST_DATA_OE: assert property (
    pins[0].data_pin_oe |-> pins[0].sync_mode && pins[0].tx_active)
    else $error("data pin driven outside sync transmit");
  AST_CLK_OE: assert property (pins[0].clk_pin_oe |-> pins[0].port_own)
    else $error("clock pin driven with port off");
endmodule

bind usart_receive_control usart_receive_control_monitor mon_u (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .pins, .irq
);

//--- tb/test_usart_receive_control.sv
`timescale 1ns/100ps

module test_usart_receive_control;
  import usart_rx_pkg::*;
  logic            pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0]     paddr = '0;
  logic [31:0]     pwdata = '0, prdata;
  logic            pready, pslverr, irq, fire = 0, chan = 0, f, n;
  rx_event_t       ev_in = '0;
  rx_event_t [1:0] rx_ev;
  logic [1:0]      shift_empty;
  pin_ctl_t [1:0]  pins;
  logic [32:0]     expq[$];
  int              fail_count = 0, samples_checked = 0;

  always #2 pclk = ~pclk;
  usart_receive_control dut_u (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_ev, .shift_empty,
    .pins, .irq);
  rx_datapath_model src_u (.pclk, .presetn, .fire, .chan, .ev_in, .rx_ev,
    .shift_empty);

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    if (fail_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [32:0] e);
    int k;
    k = 0;
    if (!w) expq.push_back(e);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    psel <= 0;
    penable <= 0;
    if (pready !== 1'b1) begin
      fail_count++;
      test_done();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1, a, d, '0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    apb(0, a, '0, e);
  endtask
  task automatic pin(input logic [6:0] e);
    repeat (3) @(posedge pclk);
    chk({26'h0, pins[0]}, {26'h0, e});
  endtask
  task automatic irqchk(input logic e);
    repeat (3) @(posedge pclk);
    chk({32'h0, irq}, {32'h0, e});
  endtask
  task automatic ev(input logic c, input logic [3:0] e);
    @(posedge pclk);
    fire <= 1;
    chan <= c;
    ev_in <= e;
    @(posedge pclk);
    fire <= 0;
  endtask

  // ----------------------------------------------------------------
  // read results matched against the oldest note
  // ----------------------------------------------------------------
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0)
      chk({pslverr, prdata}, expq.pop_front());
  end

  initial begin
    void'($urandom(7215));
    repeat (12) @(posedge pclk);
    presetn <= 1;
    rd(12'h04C, 33'h0);
    rd(12'h054, 33'h2);
    rd(12'h454, 33'h0);
    rd(12'h100, 33'h1_0000_0000);
    wr(12'h04C, 32'hFF);
    pin(7'b1101001);
    rd(12'h04C, 33'hF0);
    wr(12'h44C, 32'h90);
    rd(12'h44C, 33'h90);
    wr(12'h454, 32'hFF);
    rd(12'h454, 33'hF1);
    wr(12'h04C, 32'h90);
    pin(7'b1101000);
    ev(0, 4'b0001);
    rd(12'h04C, 33'h92);
    wr(12'h04C, 32'h92);
    rd(12'h04C, 33'h92);
    wr(12'h04C, 32'h80);
    rd(12'h04C, 33'h80);
    wr(12'h04C, 32'hC0);
    for (int i = 0; i < 4; i++) begin
      f = 1'($urandom);
      n = 1'($urandom);
      ev(0, {1'b1, n, f, 1'b0});
      rd(12'h04C, {25'h0, 5'b11000, f, 1'b0, n});
    end
    wr(12'h04C, 32'h80);
    ev(0, 4'b1100);
    rd(12'h04C, {25'h0, 7'h40, n});
    wr(12'h800, 32'hFF);
    wr(12'h804, 32'h00);
    ev(1, 4'b0001);
    rd(12'h800, 33'h40);
    irqchk(0);
    wr(12'h804, 32'h40);
    irqchk(1);
    wr(12'h800, 32'h40);
    irqchk(0);
    rd(12'h800, 33'h0);
    wr(12'h054, 32'h30);
    wr(12'h04C, 32'h90);
    pin(7'b1001010);
    wr(12'h04C, 32'h80);
    pin(7'b1010110);
    wr(12'h054, 32'hB0);
    wr(12'h04C, 32'hA0);
    pin(7'b1101010);
    ev(0, 4'b1000);
    rd(12'h04C, {25'h0, 7'h40, n});
    pin(7'b1110110);
    presetn <= 0;
    repeat (3) @(posedge pclk);
    chk({26'h0, pins[0]}, 33'h0);
    presetn <= 1;
    rd(12'h04C, 33'h0);
    rd(12'h054, 33'h2);
    repeat (4) @(posedge pclk);
    test_done();
  end
endmodule
